// File: rtl/protected_link_receiver_ports.sv
// Receiver ports: DDC register space, key port, stream decryption, repeater port.
// Assumes the authentication engine, video and repeater logic all run on mclk.
`timescale 1ns/100ps
module protected_link_receiver_ports
  import link_rx_pkg::*;
#(
  parameter int MSG_DEPTH = 1023,
  parameter int LIST_DEPTH = 160,
  parameter logic [6:0] TARGET_ADDR = DDC_TARGET_ADDR
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output msg_byte_s in_msg,
  input wire logic in_msg_ready,
  input wire msg_byte_s out_msg,
  output logic out_msg_ready,
  input wire logic reauth_req,
  input wire logic list_ready_flag,
  input wire logic fetch_start,
  input wire key_sel_e fetch_sel,
  output logic [7:0] key_addr,
  output logic key_rd,
  input wire logic [31:0] key_rdata,
  output logic [31:0] key_word,
  output logic key_word_valid,
  output logic fetch_busy,
  input wire video_s video_in,
  input wire logic encryption_status_signal,
  input wire logic [PIXEL_W-1:0] keystream,
  output logic keystream_advance,
  output video_s video_out,
  input wire logic [1:0] rpt_address,
  input wire logic rpt_write,
  input wire logic rpt_read,
  input wire logic [31:0] rpt_writedata,
  output logic [31:0] rpt_readdata,
  input wire logic rpt_request,
  input wire logic rpt_ready,
  output logic [15:0] topology_info,
  output logic list_valid,
  output logic [7:0] list_len,
  input wire logic [7:0] list_idx,
  output logic [7:0] downstream_id_list,
  input wire logic list_taken
);
  logic wr_pulse, wr_first, rd_pulse, stop_pulse;
  logic [7:0] wr_byte, rd_byte;
  logic [7:0] ptr_r;
  logic [7:0] in_buf [MSG_DEPTH];
  logic [7:0] out_buf [MSG_DEPTH];
  logic [7:0] list_buf [LIST_DEPTH];
  logic [MSG_SIZE_W-1:0] in_cnt_r, in_idx_r, out_cnt_r, out_rd_r;
  logic in_send_r, out_pending_r;
  logic [MSG_SIZE_W-1:0] msg_size;
  logic frame_enc_r, vsync_d_r;
  logic decrypt_now;

  ddc_target #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_ddc (
    .mclk(mclk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_pulse(wr_pulse),
    .wr_first(wr_first),
    .wr_byte(wr_byte),
    .rd_pulse(rd_pulse),
    .rd_byte(rd_byte),
    .stop_pulse(stop_pulse)
  );

  key_port_fetch u_key (
    .mclk(mclk),
    .resetn(resetn),
    .fetch_start(fetch_start),
    .fetch_sel(fetch_sel),
    .key_addr(key_addr),
    .key_rd(key_rd),
    .key_rdata(key_rdata),
    .key_word(key_word),
    .key_word_valid(key_word_valid),
    .fetch_busy(fetch_busy)
  );

  // Message ports keep their offset over a burst; others step
  function automatic logic is_burst_port(input logic [7:0] ofs);
    is_burst_port = (ofs == OFS_INBOUND_MESSAGE) || (ofs == OFS_OUTBOUND_MESSAGE);
  endfunction

  assign msg_size = out_pending_r ? (out_cnt_r - out_rd_r) : '0;

  // Register read map
  always_comb
  begin
    case (ptr_r)
      OFS_PROTOCOL_VERSION: rd_byte = PROTOCOL_VERSION_RESET;
      OFS_SIZE_LOW: rd_byte = msg_size[7:0];
      OFS_SIZE_HIGH:
      begin
        rd_byte = 8'h00;
        rd_byte[1:0] = msg_size[MSG_SIZE_W-1:8];
        rd_byte[STATUS_READY_BIT] = list_ready_flag;
        rd_byte[STATUS_REAUTH_BIT] = reauth_req;
      end
      OFS_OUTBOUND_MESSAGE: rd_byte = out_pending_r ? out_buf[out_rd_r] : 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  // Offset pointer: set by first written byte, steps outside message ports
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ptr_r <= 8'h00;
    else if (wr_pulse && wr_first)
      ptr_r <= wr_byte;
    else if ((wr_pulse || rd_pulse) && !is_burst_port(ptr_r))
      ptr_r <= ptr_r + 8'h01;
  end

  // Inbound burst collected, handed on after stop
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      in_cnt_r <= '0;
      in_idx_r <= '0;
      in_send_r <= 1'b0;
    end
    else if (in_send_r)
    begin
      if (in_msg_ready)
      begin
        in_idx_r <= in_idx_r + 1'b1;
        if (in_idx_r == in_cnt_r - 1'b1)
        begin
          in_send_r <= 1'b0;
          in_cnt_r <= '0;
        end
      end
    end
    else if (wr_pulse && !wr_first && ptr_r == OFS_INBOUND_MESSAGE)
    begin
      if (int'(in_cnt_r) < MSG_DEPTH)
      begin
        in_buf[in_cnt_r] <= wr_byte;
        in_cnt_r <= in_cnt_r + 1'b1;
      end
    end
    else if (stop_pulse && in_cnt_r != '0)
    begin
      in_send_r <= 1'b1;
      in_idx_r <= '0;
    end
  end

  assign in_msg.byte_val = in_send_r ? in_buf[in_idx_r] : 8'h00;
  assign in_msg.valid = in_send_r;
  assign in_msg.last = in_send_r && (in_idx_r == in_cnt_r - 1'b1);

  // Outbound message loaded by the engine, drained by burst reads
  assign out_msg_ready = !out_pending_r;
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      out_cnt_r <= '0;
      out_rd_r <= '0;
      out_pending_r <= 1'b0;
    end
    else if (out_pending_r)
    begin
      if (rd_pulse && ptr_r == OFS_OUTBOUND_MESSAGE)
      begin
        out_rd_r <= out_rd_r + 1'b1;
        if (out_rd_r == out_cnt_r - 1'b1)
        begin
          out_pending_r <= 1'b0;
          out_cnt_r <= '0;
        end
      end
    end
    else if (out_msg.valid && int'(out_cnt_r) < MSG_DEPTH)
    begin
      out_buf[out_cnt_r] <= out_msg.byte_val;
      out_cnt_r <= out_cnt_r + 1'b1;
      if (out_msg.last)
      begin
        out_pending_r <= 1'b1;
        out_rd_r <= '0;
      end
    end
  end

  // Frame choice latched at frame start
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      frame_enc_r <= 1'b0;
      vsync_d_r <= 1'b0;
    end
    else
    begin
      vsync_d_r <= video_in.vsync;
      if (video_in.vsync && !vsync_d_r)
        frame_enc_r <= encryption_status_signal;
    end
  end

  assign decrypt_now = frame_enc_r && video_in.de;
  assign keystream_advance = decrypt_now;

  // Decrypted stream out, one cycle later
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      video_out <= '0;
    else
    begin
      video_out <= video_in;
      if (decrypt_now)
        video_out.pixel <= video_in.pixel ^ keystream;
    end
  end

  // Repeater message port, sharing mclk with the register port
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      list_len <= 8'h00;
      topology_info <= 16'h0000;
      list_valid <= 1'b0;
    end
    else
    begin
      if (rpt_write && rpt_address == RPT_ADDR_ID_LIST && int'(list_len) < LIST_DEPTH)
      begin
        list_buf[list_len] <= rpt_writedata[7:0];
        list_len <= list_len + 8'h01;
      end
      else if (list_taken && !(rpt_write && rpt_address == RPT_ADDR_TOPOLOGY))
        list_len <= 8'h00;
      if (rpt_write && rpt_address == RPT_ADDR_TOPOLOGY)
      begin
        topology_info <= rpt_writedata[15:0];
        list_valid <= 1'b1;
      end
      else if (list_taken)
        list_valid <= 1'b0;
    end
  end

  // List bytes and topology forwarded to the engine for MAC and upstream
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      downstream_id_list <= 8'h00;
      rpt_readdata <= 32'h0000_0000;
    end
    else
    begin
      downstream_id_list <= (int'(list_idx) < LIST_DEPTH) ? list_buf[list_idx] : 8'h00;
      if (rpt_read && rpt_address == RPT_ADDR_TOPOLOGY)
      begin
        rpt_readdata <= {16'h0000, topology_info};
        rpt_readdata[RPT_REQUEST_BIT] <= rpt_request;
        rpt_readdata[RPT_READY_BIT] <= rpt_ready;
        rpt_readdata[RPT_VALID_BIT] <= list_valid;
      end
      else if (rpt_read)
        rpt_readdata <= 32'h0000_0000;
    end
  end
endmodule

// File: rtl/link_rx_pkg.sv
// Constants, types and address map shared by the protected link receiver ports.
// Assumes one clock domain (mclk) for every file that imports it.
// Function
// - Core does not run authentication; the engine outside does, and the core answers only transmitter accesses to its registers.
// - Transmitter reaches registers over the display data channel by I2C; core is target.
// - Global constant, private key and certificate must be supplied before authentication.
// - No key held inside; 32-bit words fetched by 8-bit address on the key port.
// - Video content comes in and leaves decrypted.
// - Encryption status signalling picks frames to decrypt; others pass unchanged.
// - Downstream ID list and topology info forwarded upstream and fed to the MAC.
// - Register port and repeater message port may share one clock.
// - Register offsets follow the standard version-2 receiver layout.
// - Version register at 50 resets to 04; bit 2 marks revision 2.2 support.
// - Each inbound message is one burst write to 60, collected as one message.
// - Each outbound message is one burst read from 80, bytes in order.
// - Pending message size: low byte at 70, upper two bits in 71 bits 1:0.
package link_rx_pkg;
  localparam logic [7:0] OFS_RSVD_LOW_FIRST = 8'h44;
  localparam logic [7:0] OFS_RSVD_LOW_LAST = 8'h4f;
  localparam logic [7:0] OFS_PROTOCOL_VERSION = 8'h50;
  localparam logic [7:0] OFS_RSVD_MID_FIRST = 8'h51;
  localparam logic [7:0] OFS_RSVD_MID_LAST = 8'h5f;
  localparam logic [7:0] OFS_INBOUND_MESSAGE = 8'h60;
  localparam logic [7:0] OFS_SIZE_LOW = 8'h70;
  localparam logic [7:0] OFS_SIZE_HIGH = 8'h71;
  localparam logic [7:0] OFS_OUTBOUND_MESSAGE = 8'h80;
  localparam logic [7:0] PROTOCOL_VERSION_RESET = 8'h04;
  localparam int VERSION_TWO_CAPABLE_BIT = 2;
  localparam int STATUS_READY_BIT = 2;
  localparam int STATUS_REAUTH_BIT = 3;
  localparam logic [6:0] DDC_TARGET_ADDR = 7'h3a;
  // Key memory word map
  localparam logic [7:0] KEY_GC_BASE = 8'he0;
  localparam logic [7:0] KEY_GC_WORDS = 8'h04;
  localparam logic [7:0] KEY_P_BASE = 8'hd0;
  localparam logic [7:0] KEY_Q_BASE = 8'hc0;
  localparam logic [7:0] KEY_DP_BASE = 8'hb0;
  localparam logic [7:0] KEY_DQ_BASE = 8'ha0;
  localparam logic [7:0] KEY_QINV_BASE = 8'h90;
  localparam logic [7:0] KEY_PRIV_WORDS = 8'h10;
  localparam logic [7:0] KEY_CERT_BASE = 8'h00;
  localparam logic [7:0] KEY_CERT_WORDS = 8'h83;
  // Repeater message port word addresses and status bits
  localparam logic [1:0] RPT_ADDR_ID_LIST = 2'h0;
  localparam logic [1:0] RPT_ADDR_TOPOLOGY = 2'h1;
  localparam int RPT_REQUEST_BIT = 18;
  localparam int RPT_READY_BIT = 17;
  localparam int RPT_VALID_BIT = 16;
  localparam int MSG_SIZE_W = 10;
  localparam int PIXEL_W = 24;

  typedef enum logic [2:0] {
    KEY_GLOBAL_CONSTANT,
    KEY_PRIVATE_P,
    KEY_PRIVATE_Q,
    KEY_PRIVATE_EXPONENT_FIRST,
    KEY_PRIVATE_DQ,
    KEY_PRIVATE_QINV,
    KEY_CERTIFICATE
  } key_sel_e;

  typedef struct packed {
    logic [PIXEL_W-1:0] pixel;
    logic de;
    logic hsync;
    logic vsync;
  } video_s;

  typedef struct packed {
    logic [7:0] byte_val;
    logic valid;
    logic last;
  } msg_byte_s;
endpackage

// File: rtl/ddc_target.sv
// I2C target on the display data channel: byte events toward the register file.
// Assumes scl and sda arrive from pins and are slow against mclk.
`timescale 1ns/100ps
module ddc_target
  import link_rx_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = DDC_TARGET_ADDR
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_pulse,
  output logic wr_first,
  output logic [7:0] wr_byte,
  output logic rd_pulse,
  input wire logic [7:0] rd_byte,
  output logic stop_pulse
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} ddc_state_e;
  ddc_state_e state_r;
  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_r, sda_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic drive_low_r, first_r, nack_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = scl_sync_r[1] && !scl_r;
  assign scl_fall = !scl_sync_r[1] && scl_r;
  assign start_cond = scl_sync_r[1] && scl_r && sda_r && !sda_sync_r[1];
  assign stop_cond = scl_sync_r[1] && scl_r && !sda_r && sda_sync_r[1];
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_r;
  assign wr_byte = shift_r;

  always_ff @(posedge mclk)
  begin
    scl_sync_r <= {scl_sync_r[0], scl_in};
    sda_sync_r <= {sda_sync_r[0], sda_in};
    scl_r <= scl_sync_r[1];
    sda_r <= sda_sync_r[1];
  end

  // Bit sequencing; target of transmitter transactions
  always_ff @(posedge mclk)
  begin
    wr_pulse <= 1'b0;
    rd_pulse <= 1'b0;
    stop_pulse <= 1'b0;
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      drive_low_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      wr_first <= 1'b0;
    end
    else if (start_cond)
    begin
      state_r <= ST_ADDR;
      cnt_r <= 4'h0;
      drive_low_r <= 1'b0;
      stop_pulse <= (state_r != ST_IDLE);
    end
    else if (stop_cond)
    begin
      state_r <= ST_IDLE;
      drive_low_r <= 1'b0;
      stop_pulse <= (state_r != ST_IDLE);
    end
    else if (scl_rise && state_r != ST_IDLE)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (state_r != ST_READ && cnt_r < 4'h8)
        shift_r <= {shift_r[6:0], sda_r};
      if (state_r == ST_READ && cnt_r == 4'h8)
        nack_r <= sda_r;
    end
    else if (scl_fall && state_r != ST_IDLE)
    begin
      if (cnt_r == 4'h8)
      begin
        if (state_r == ST_ADDR)
        begin
          drive_low_r <= (shift_r[7:1] == TARGET_ADDR);
          if (shift_r[7:1] != TARGET_ADDR)
            state_r <= ST_IDLE;
        end
        else if (state_r == ST_WRITE)
        begin
          drive_low_r <= 1'b1;
          wr_pulse <= 1'b1;
          wr_first <= first_r;
          first_r <= 1'b0;
        end
        else
          drive_low_r <= 1'b0;
      end
      else if (cnt_r == 4'h9)
      begin
        cnt_r <= 4'h0;
        drive_low_r <= 1'b0;
        if (state_r == ST_ADDR && !shift_r[0])
        begin
          state_r <= ST_WRITE;
          first_r <= 1'b1;
        end
        else if (state_r == ST_WRITE)
          state_r <= ST_WRITE;
        else if (state_r == ST_ADDR || !nack_r)
        begin
          state_r <= ST_READ;
          shift_r <= rd_byte;
          rd_pulse <= 1'b1;
          drive_low_r <= !rd_byte[7];
        end
        else
          state_r <= ST_IDLE;
      end
      else if (state_r == ST_READ && cnt_r < 4'h8)
        drive_low_r <= !shift_r[3'h7 - cnt_r[2:0]];
    end
  end
endmodule

// File: rtl/key_port_fetch.sv
// Walks one key region of the external key memory, low word first.
// Assumes the key memory returns data one mclk after the read strobe.
`timescale 1ns/100ps
module key_port_fetch
  import link_rx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic fetch_start,
  input wire key_sel_e fetch_sel,
  output logic [7:0] key_addr,
  output logic key_rd,
  input wire logic [31:0] key_rdata,
  output logic [31:0] key_word,
  output logic key_word_valid,
  output logic fetch_busy
);
  logic [7:0] left_r;
  logic rd_d_r;
  logic [15:0] region_sel;

  // Region base and size per key item
  function automatic logic [15:0] region(input key_sel_e sel);
    case (sel)
      KEY_GLOBAL_CONSTANT: region = {KEY_GC_BASE, KEY_GC_WORDS};
      KEY_PRIVATE_P: region = {KEY_P_BASE, KEY_PRIV_WORDS};
      KEY_PRIVATE_Q: region = {KEY_Q_BASE, KEY_PRIV_WORDS};
      KEY_PRIVATE_EXPONENT_FIRST: region = {KEY_DP_BASE, KEY_PRIV_WORDS};
      KEY_PRIVATE_DQ: region = {KEY_DQ_BASE, KEY_PRIV_WORDS};
      KEY_PRIVATE_QINV: region = {KEY_QINV_BASE, KEY_PRIV_WORDS};
      KEY_CERTIFICATE: region = {KEY_CERT_BASE, KEY_CERT_WORDS};
      default: region = {KEY_GC_BASE, KEY_GC_WORDS};
    endcase
  endfunction

  assign region_sel = region(fetch_sel);
  assign fetch_busy = (left_r != 8'h00);
  assign key_rd = fetch_busy;

  // Key words come from outside only, one per cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      left_r <= 8'h00;
      key_addr <= 8'h00;
      rd_d_r <= 1'b0;
      key_word <= 32'h0000_0000;
      key_word_valid <= 1'b0;
    end
    else
    begin
      rd_d_r <= key_rd;
      key_word_valid <= rd_d_r;
      if (rd_d_r)
        key_word <= key_rdata;
      if (fetch_start && !fetch_busy)
      begin
        key_addr <= region_sel[15:8];
        left_r <= region_sel[7:0];
      end
      else if (fetch_busy)
      begin
        left_r <= left_r - 8'h01;
        if (left_r != 8'h01)
          key_addr <= key_addr + 8'h01;
      end
    end
  end
endmodule

// File: test/ddc_host.sv
// Upstream transmitter model: I2C controller on the display data channel.
// Assumes the bench resolves the open-drain sda wire with a pull-up.
`timescale 1ns/100ps
module ddc_host
  import link_rx_pkg::*;
(
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  int nacks = 0;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (3) @(posedge mclk);
  endtask
  task automatic clk_bit(input logic b, output logic r);
    scl <= 1'b0;
    q();
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda_in;
    q();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, input logic chk,
    output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, a);
    if (chk && a) nacks++;
  endtask
  task automatic start();
    scl <= 1'b0;
    q();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
  endtask
  task automatic stop();
    scl <= 1'b0;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d[$]);
    logic [7:0] r;
    start();
    xfer({DDC_TARGET_ADDR, 1'b0}, 1'b1, 1'b1, r);
    xfer(ofs, 1'b1, 1'b1, r);
    foreach (d[i]) xfer(d[i], 1'b1, 1'b1, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, input int n, output logic [7:0] d[$]);
    logic [7:0] r;
    d = {};
    start();
    xfer({DDC_TARGET_ADDR, 1'b0}, 1'b1, 1'b1, r);
    xfer(ofs, 1'b1, 1'b1, r);
    start();
    xfer({DDC_TARGET_ADDR, 1'b1}, 1'b1, 1'b1, r);
    for (int i = 0; i < n; i++)
    begin
      xfer(8'hff, i == n - 1, 1'b0, r);
      d.push_back(r);
    end
    stop();
  endtask
endmodule

// File: test/link_rx_checker.sv
// Checker for key fetch, stream path, repeater list and inbound stream.
// Assumes it is bound into the top module and everything runs on mclk.
`timescale 1ns/100ps
module link_rx_checker
  import link_rx_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire msg_byte_s in_msg,
  input wire logic in_msg_ready,
  input wire logic fetch_start,
  input wire key_sel_e fetch_sel,
  input wire logic fetch_busy,
  input wire logic [7:0] key_addr,
  input wire logic key_rd,
  input wire logic [31:0] key_rdata,
  input wire logic [31:0] key_word,
  input wire logic key_word_valid,
  input wire video_s video_in,
  input wire logic [PIXEL_W-1:0] keystream,
  input wire logic keystream_advance,
  input wire video_s video_out,
  input wire logic [1:0] rpt_address,
  input wire logic rpt_write,
  input wire logic list_valid,
  input wire logic [7:0] list_len,
  input wire logic list_taken
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  AST_KEY_STEP: assert property (key_rd && $past(key_rd) |-> key_addr == $past(key_addr) + 8'h01)
    else $error("key address did not step by one");
  AST_KEY_VALID: assert property (key_rd |-> ##2 key_word_valid)
    else $error("key word not delivered two cycles after read");
  AST_KEY_WORD: assert property (key_word_valid |-> key_word == $past(key_rdata))
    else $error("key word differs from memory data");
  AST_GC_FIRST: assert property (fetch_start && !fetch_busy && fetch_sel == KEY_GLOBAL_CONSTANT
    |-> ##[1:3] (key_rd && key_addr == KEY_GC_BASE))
    else $error("constant fetch did not start at its base word");
  AST_VIDEO_PIX: assert property ($past(resetn) |->
    video_out.pixel == $past(video_in.pixel ^ (keystream_advance ? keystream : '0)))
    else $error("output pixel wrong");
  AST_VIDEO_SYNC: assert property ($past(resetn) |->
    {video_out.de, video_out.hsync, video_out.vsync}
    == $past({video_in.de, video_in.hsync, video_in.vsync}))
    else $error("timing signals not passed with one cycle delay");
  AST_ADV_DE: assert property (keystream_advance |-> video_in.de)
    else $error("keystream advanced outside active video");
  AST_LIST_SET: assert property (rpt_write && rpt_address == RPT_ADDR_TOPOLOGY |=> list_valid)
    else $error("list not marked valid after topology write");
  AST_LIST_CLEAR: assert property (list_taken && !(rpt_write && rpt_address == RPT_ADDR_TOPOLOGY)
    |=> !list_valid && list_len == 8'h00)
    else $error("list not cleared when taken");
  AST_IN_HOLD: assert property (in_msg.valid && !in_msg_ready
    |=> in_msg.valid && $stable(in_msg.byte_val) && $stable(in_msg.last))
    else $error("inbound byte changed while stalled");
  COV_FETCH: cover property ($fell(fetch_busy));
  COV_DECRYPT: cover property (keystream_advance);
  COV_LIST: cover property (list_valid ##1 !list_valid);
  COV_STALL: cover property (in_msg.valid && !in_msg_ready);
endmodule

// File: test/protected_link_receiver_ports_bench.sv
// Bench for the receiver ports: register space over I2C, key port, stream, repeater.
// Assumes the transmitter model in ddc_host and a key memory with one-cycle read.
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
module protected_link_receiver_ports_bench
  import link_rx_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic in_msg_ready = 1'b0, reauth_req = 1'b1, list_ready_flag = 1'b0, fetch_start = 1'b0;
  logic encryption_status_signal = 1'b0, rpt_write = 1'b0, rpt_read = 1'b0, list_taken = 1'b0;
  logic rpt_request = 1'b0, rpt_ready = 1'b1;
  logic [1:0] rpt_address = 2'h0;
  logic [7:0] list_idx = 8'h01;
  logic [31:0] key_rdata = '0, rpt_writedata = '0, rd_word;
  logic [PIXEL_W-1:0] keystream = '0;
  msg_byte_s out_msg = '0;
  key_sel_e fetch_sel = KEY_GLOBAL_CONSTANT;
  video_s video_in = '0;
  logic scl_in, sda_low, sda_out, sda_oe, out_msg_ready, key_rd, key_word_valid, fetch_busy;
  logic keystream_advance, list_valid;
  logic [7:0] key_addr, list_len, downstream_id_list;
  logic [15:0] topology_info;
  logic [31:0] key_word, rpt_readdata;
  msg_byte_s in_msg;
  video_s video_out;
  wire logic sda_in;
  int checked = 0;
  int n_mismatch = 0;
  int cyc = 0;
  logic [8:0] got[$];
  logic [7:0] offs[5] = '{8'h44, 8'h4f, 8'h50, 8'h51, 8'h5f};
  logic [7:0] kb[7] = '{8'he0, 8'hd0, 8'hc0, 8'hb0, 8'ha0, 8'h90, 8'h00};
  int kn[7] = '{4, 16, 16, 16, 16, 16, 131};

  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  protected_link_receiver_ports i_dut (.*);
  ddc_host i_host (.mclk(mclk), .sda_in(sda_in), .scl(scl_in), .sda_low(sda_low));

  always #50 mclk = !mclk;
  always @(posedge mclk) in_msg_ready <= !in_msg_ready;
  always @(posedge mclk) key_rdata <= key_rd ? {24'h5a5a5a, key_addr} : ~key_rdata;
  always @(posedge mclk)
  begin
    if (in_msg.valid && in_msg_ready) got.push_back({in_msg.last, in_msg.byte_val});
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rpt(input logic w, input logic [1:0] a, input logic [31:0] d);
    rpt_write <= w;
    rpt_read <= !w;
    rpt_address <= a;
    rpt_writedata <= d;
    @(posedge mclk);
    #1;
    rd_word = rpt_readdata;
    rpt_write <= 1'b0;
    rpt_read <= 1'b0;
    @(posedge mclk);
  endtask

  initial
  begin
    logic [7:0] d[$];
    logic [7:0] fa, la;
    int n;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    foreach (offs[i])
    begin
      i_host.wr(offs[i], {8'haa});
      i_host.rd(offs[i], 1, d);
      `CHK(d[0], offs[i] == OFS_PROTOCOL_VERSION ? PROTOCOL_VERSION_RESET : 8'h00)
    end
    $display("test registers done");
    i_host.wr(OFS_INBOUND_MESSAGE, {8'ha1, 8'hb2, 8'hc3});
    repeat (20) @(posedge mclk);
    `CHK({got.size() == 3, got[0], got[1], got[2]}, {1'b1, 9'h0a1, 9'h0b2, 9'h1c3})
    $display("test inbound done");
    for (int i = 0; i < 3; i++)
    begin
      out_msg <= '{byte_val: 8'h5c + 8'(17 * i), valid: 1'b1, last: (i == 2)};
      @(posedge mclk);
    end
    out_msg <= '0;
    @(posedge mclk);
    #1;
    `CHK(out_msg_ready, 1'b0)
    i_host.rd(OFS_SIZE_LOW, 2, d);
    `CHK({d[0], d[1]}, 16'h0308)
    i_host.rd(OFS_OUTBOUND_MESSAGE, 3, d);
    `CHK({d[0], d[1], d[2]}, 24'h5c6d7e)
    i_host.rd(OFS_SIZE_LOW, 1, d);
    `CHK({d[0], out_msg_ready, i_host.nacks == 0}, 10'h003)
    $display("test outbound done");
    for (int s = 0; s < 7; s++)
    begin
      fetch_sel <= key_sel_e'(s);
      fetch_start <= 1'b1;
      @(posedge mclk);
      fetch_start <= 1'b0;
      n = 0;
      for (int c = 0; c < 200 && (n == 0 || key_rd); c++)
      begin
        #1;
        if (key_rd && n == 0) fa = key_addr;
        if (key_rd) la = key_addr;
        n += key_rd;
        @(posedge mclk);
      end
      `CHK({n == kn[s], fa, la}, {1'b1, kb[s], kb[s] + 8'(kn[s] - 1)})
      repeat (4) @(posedge mclk);
    end
    $display("test key port done");
    for (int e = 1; e >= 0; e--)
    begin
      encryption_status_signal <= e[0];
      video_in <= '0;
      @(posedge mclk);
      video_in.vsync <= 1'b1;
      @(posedge mclk);
      video_in <= '{24'h123456, 1'b1, 1'b0, 1'b0};
      keystream <= 24'h0f0f0f;
      @(posedge mclk);
      #1;
      `CHK({keystream_advance, video_out.pixel}, {e[0], e ? 24'h1d3b59 : 24'h123456})
    end
    $display("test stream done");
    for (int i = 0; i < 3; i++) rpt(1'b1, RPT_ADDR_ID_LIST, 32'(17 * (i + 1)));
    rpt(1'b1, RPT_ADDR_TOPOLOGY, 32'h00000235);
    @(posedge mclk);
    #1;
    `CHK({list_valid, list_len, topology_info, downstream_id_list}, 33'h1_0302_3522)
    rpt(1'b0, RPT_ADDR_TOPOLOGY, 32'h0);
    `CHK(rd_word, 32'h00030235)
    list_taken <= 1'b1;
    @(posedge mclk);
    list_taken <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK({list_valid, list_len}, 9'h000)
    $display("test repeater done");
    give_verdict();
  end
endmodule
bind protected_link_receiver_ports link_rx_checker i_chk (.*);
